/* logic/adc_ctrl_pkg.sv */
/*
 * Package for the converter control block: register indices, field
 * layouts, reset values, state codes and timing counts.
 * Assumes byte addresses are four times the register index.
 */
`default_nettype none
package adc_ctrl_pkg;
    // Register indices; byte address is index * 4
    localparam logic [5:0] IDX_ENABLE_CONTROL = 6'h00;
    localparam logic [5:0] IDX_SAMPLING_TIME  = 6'h03;
    localparam logic [5:0] IDX_CONVERSION     = 6'h04;
    localparam logic [5:0] IDX_STATUS         = 6'h06;
    localparam logic [5:0] IDX_WINDOW_MODE    = 6'h08;
    localparam logic [5:0] IDX_TRIGGER        = 6'h0C;
    localparam logic [5:0] IDX_RESULT         = 6'h1A;
    localparam logic [5:0] IDX_WINDOW_LOWER   = 6'h1C;
    localparam logic [5:0] IDX_WINDOW_UPPER   = 6'h20;
    localparam logic [5:0] IDX_GAIN_CAL       = 6'h24;
    localparam logic [5:0] IDX_OFFSET_CAL     = 6'h26;

    // Field positions
    localparam int ENABLE_BIT     = 1;
    localparam int START_BIT      = 1;
    localparam int FLUSH_BIT      = 0;
    localparam int ST_SYNC_BIT    = 0;
    localparam int ST_WINDOW_BIT  = 1;
    localparam int ST_BUSY_BIT    = 2;

    // Reset values
    localparam logic [5:0]  SAMPLE_LENGTH_RST = 6'h00;
    localparam logic [2:0]  WINDOW_MODE_RST   = 3'h0;
    localparam logic [11:0] GAIN_CAL_RST      = 12'h800;
    localparam logic [11:0] OFFSET_CAL_RST    = 12'h000;
    localparam logic [15:0] LIMIT_RST         = 16'h0000;

    // Cycles from an enable write until the new state is active
    localparam logic [1:0]  SYNC_CYCLES       = 2'h3;
    // Gain calibration is unsigned with 11 fraction bits
    localparam int          GAIN_FRAC_BITS    = 11;

    typedef enum logic [1:0] {
        RES_12BIT = 2'h0,
        RES_16BIT = 2'h1,
        RES_10BIT = 2'h2,
        RES_8BIT  = 2'h3
    } resolution_t;

    typedef enum logic [2:0] {
        WIN_OFF     = 3'h0,
        WIN_ABOVE   = 3'h1,
        WIN_BELOW   = 3'h2,
        WIN_INSIDE  = 3'h3,
        WIN_OUTSIDE = 3'h4
    } window_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_SAMPLE  = 5'b00010,
        ST_CONVERT = 5'b00100,
        ST_CORRECT = 5'b01000,
        ST_STORE   = 5'b10000
    } conv_state_t;

    typedef struct packed {
        logic [4:0]  rsv_hi;
        logic [2:0]  prescaler;
        logic [1:0]  rsv_lo;
        resolution_t resolution_select;
        logic        correction_enable;
        logic        continuous_convert;
        logic        left_align;
        logic        differential_select;
    } conv_ctrl_t;

    typedef struct packed {
        logic        differential_select;
        resolution_t resolution_select;
    } core_cfg_t;
endpackage
`default_nettype wire

/* logic/adc_conversion_control.sv */
/*
 * Converter control block: APB register file, converter clock prescaler,
 * sampling timer, conversion sequencer, gain/offset correction, result
 * formatting and window monitor.
 * Assumes the analog core runs on pclk, samples while core_sample is high,
 * converts on core_start, advances on conv_tick and returns core_done with
 * core_raw in the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Sample for sample_length+1 converter half-periods
// - Reserved bits always read zero
// - Prescaler divides pclk by 4 to 512
// - Conversion settings writable only while disabled
// - Resolution selects 12, 16, 10, 8 bits; the 16-bit setting is formatted like 12-bit
// - Correction applies gain and offset calibration
// - Correction adds offset-dependent extra cycles
// - Continuous mode restarts after each completion
// - Left alignment moves result to top
// - Differential mode converts input difference
// - Window mode selects comparison against limits
// - Start bit begins conversion, self-clears
// - Writing zero to start or flush ignored
// - Flush restarts clock, aborts conversions
// - Flush bit clears when flush done
// - After flush pending conversion restarts
// - Enable reads back, sync busy meanwhile
// - Protection unit may lock register writes
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    // APB slave
    input  wire  logic [7:0]  paddr,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [31:0] pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Access protection unit
    input  wire  logic        write_lock,
    // Analog core
    output logic              core_sample,
    output logic              core_start,
    output logic              core_abort,
    output logic              conv_tick,
    output core_cfg_t         core_cfg,
    input  wire  logic        core_done,
    input  wire  logic [11:0] core_raw
);
    // Register state
    logic               enable_req_ff;
    logic               enabled_ff;
    logic [1:0]         sync_cnt_ff;
    logic [5:0]         sample_length_ff;
    conv_ctrl_t         conv_ctrl_ff;
    logic [2:0]         window_mode_ff;
    logic               start_pend_ff;
    logic               flush_ff;
    logic [15:0]        window_lower_ff;
    logic [15:0]        window_upper_ff;
    logic [11:0]        gain_cal_ff;
    logic [11:0]        offset_cal_ff;
    logic [15:0]        result_ff;
    logic               window_flag_ff;
    // Sequencer state
    conv_state_t        state_ff;
    conv_state_t        nxt_state;
    logic [8:0]         presc_cnt_ff;
    logic [6:0]         samp_cnt_ff;
    logic [2:0]         corr_cnt_ff;
    logic [11:0]        raw_ff;
    logic [31:0]        nxt_prdata;

    // APB decode
    wire         setup_rd   = psel & ~penable & ~pready;
    wire         acc_done   = psel & penable & pready;
    wire         wr_cycle   = acc_done & pwrite;
    wire         aligned    = (paddr[1:0] == 2'b00);
    wire  [5:0]  idx        = paddr[7:2];
    wire         hit_en     = aligned & (idx == IDX_ENABLE_CONTROL);
    wire         hit_samp   = aligned & (idx == IDX_SAMPLING_TIME);
    wire         hit_conv   = aligned & (idx == IDX_CONVERSION);
    wire         hit_stat   = aligned & (idx == IDX_STATUS);
    wire         hit_win    = aligned & (idx == IDX_WINDOW_MODE);
    wire         hit_trig   = aligned & (idx == IDX_TRIGGER);
    wire         hit_res    = aligned & (idx == IDX_RESULT);
    wire         hit_lo     = aligned & (idx == IDX_WINDOW_LOWER);
    wire         hit_hi     = aligned & (idx == IDX_WINDOW_UPPER);
    wire         hit_gain   = aligned & (idx == IDX_GAIN_CAL);
    wire         hit_offs   = aligned & (idx == IDX_OFFSET_CAL);
    wire         mapped     = hit_en | hit_samp | hit_conv | hit_stat | hit_win | hit_trig
                            | hit_res | hit_lo | hit_hi | hit_gain | hit_offs;
    // Status (write one clears window flag) and result are not lockable; everything else is lockable
    wire         lockable   = mapped & ~hit_stat & ~hit_res;
    wire         wr_ok      = wr_cycle & ~(write_lock & lockable);
    wire         sync_busy  = (sync_cnt_ff != 2'h0);
    wire         conv_open  = ~enable_req_ff & ~enabled_ff & ~sync_busy;

    assign nxt_prdata =
          hit_en   ? {30'h0, enable_req_ff, 1'b0}
        : hit_samp ? {26'h0, sample_length_ff}
        : hit_conv ? {16'h0, conv_ctrl_ff}
        : hit_stat ? {29'h0, ~state_ff[0], window_flag_ff, sync_busy}
        : hit_win  ? {29'h0, window_mode_ff}
        : hit_trig ? {30'h0, start_pend_ff, flush_ff}
        : hit_res  ? {16'h0, result_ff}
        : hit_lo   ? {16'h0, window_lower_ff}
        : hit_hi   ? {16'h0, window_upper_ff}
        : hit_gain ? {20'h0, gain_cal_ff}
        : hit_offs ? {20'h0, offset_cal_ff}
        : 32'h0000_0000;

    // Zero-wait answer: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_rd;
            prdata  <= setup_rd ? nxt_prdata : prdata;
            pslverr <= setup_rd & (~mapped | (pwrite & write_lock & lockable));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_req_ff <= 1'b0;
            enabled_ff    <= 1'b0;
            sync_cnt_ff   <= 2'h0;
        end else if (wr_ok && hit_en) begin
            enable_req_ff <= pwdata[ENABLE_BIT];
            sync_cnt_ff   <= SYNC_CYCLES;
        end else if (sync_busy) begin
            sync_cnt_ff   <= sync_cnt_ff - 2'h1;
            enabled_ff    <= (sync_cnt_ff == 2'h1) ? enable_req_ff : enabled_ff;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_length_ff <= SAMPLE_LENGTH_RST;
            conv_ctrl_ff     <= '0;
            window_mode_ff   <= WINDOW_MODE_RST;
            window_lower_ff  <= LIMIT_RST;
            window_upper_ff  <= LIMIT_RST;
            gain_cal_ff      <= GAIN_CAL_RST;
            offset_cal_ff    <= OFFSET_CAL_RST;
        end else if (wr_ok) begin
            if (hit_samp)
                sample_length_ff <= pwdata[5:0];
            if (hit_conv && conv_open)
                conv_ctrl_ff <= conv_ctrl_t'({5'h00, pwdata[10:8], 2'h0, pwdata[5:0]});
            if (hit_win)
                window_mode_ff <= pwdata[2:0];
            if (hit_lo)
                window_lower_ff <= pwdata[15:0];
            if (hit_hi)
                window_upper_ff <= pwdata[15:0];
            if (hit_gain)
                gain_cal_ff <= pwdata[11:0];
            if (hit_offs)
                offset_cal_ff <= pwdata[11:0];
        end
    end

    wire  [8:0]  half_limit = 9'(9'h002 << conv_ctrl_ff.prescaler);
    wire         half_tick  = enabled_ff & ~flush_ff & (presc_cnt_ff == 9'(half_limit - 9'h001));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            presc_cnt_ff <= 9'h000;
        else if (flush_ff || !enabled_ff || half_tick)
            presc_cnt_ff <= 9'h000;
        else
            presc_cnt_ff <= presc_cnt_ff + 9'h001;
    end

    // Sequencer transitions
    wire         go_sample  = state_ff[0] & enabled_ff & start_pend_ff & ~flush_ff;
    wire         samp_done  = half_tick & (samp_cnt_ff == {1'b0, sample_length_ff});
    wire         corr_done  = (corr_cnt_ff == offset_cal_ff[2:0]);
    wire         restart    = conv_ctrl_ff.continuous_convert;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:    if (go_sample) nxt_state = ST_SAMPLE;
            ST_SAMPLE:  if (samp_done) nxt_state = ST_CONVERT;
            ST_CONVERT: if (core_done)
                            nxt_state = conv_ctrl_ff.correction_enable ? ST_CORRECT : ST_STORE;
            ST_CORRECT: if (corr_done) nxt_state = ST_STORE;
            ST_STORE:   nxt_state = restart ? ST_SAMPLE : ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
        if (flush_ff || !enabled_ff)
            nxt_state = ST_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= ST_IDLE;
            samp_cnt_ff <= 7'h00;
            corr_cnt_ff <= 3'h0;
            raw_ff      <= 12'h000;
        end else begin
            state_ff    <= nxt_state;
            samp_cnt_ff <= (nxt_state != ST_SAMPLE || state_ff != ST_SAMPLE) ? 7'h00
                         : samp_cnt_ff + {6'h00, half_tick};
            corr_cnt_ff <= (state_ff == ST_CORRECT) ? corr_cnt_ff + 3'h1 : 3'h0;
            raw_ff      <= (state_ff == ST_CONVERT && core_done) ? core_raw : raw_ff;
        end
    end

    // Start set on write, cleared at conversion start
    wire         wr_trig    = wr_ok & hit_trig;
    wire         set_start  = wr_trig & pwdata[START_BIT];
    wire         set_flush  = wr_trig & pwdata[FLUSH_BIT];
    wire         repend     = flush_ff & ~state_ff[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pend_ff <= 1'b0;
            flush_ff      <= 1'b0;
        end else begin
            start_pend_ff <= set_start | repend | (start_pend_ff & ~go_sample);
            flush_ff      <= set_flush;
        end
    end

    // Gain and offset correction, clamped to 12 bits
    wire signed [13:0] offs_diff = $signed({2'b00, raw_ff})
                                 - $signed({{2{offset_cal_ff[11]}}, offset_cal_ff});
    wire signed [26:0] scaled    = offs_diff * $signed({1'b0, gain_cal_ff});
    wire signed [26:0] shifted   = scaled >>> GAIN_FRAC_BITS;
    wire        [11:0] corrected = shifted[26] ? 12'h000
                                 : (shifted[25:12] != 14'h0000) ? 12'hFFF : shifted[11:0];
    wire        [11:0] value12   = conv_ctrl_ff.correction_enable ? corrected : raw_ff;

    logic [15:0] formatted;
    always_comb begin
        formatted = {4'h0, value12};
        unique case (conv_ctrl_ff.resolution_select)
            RES_12BIT, RES_16BIT:
                formatted = conv_ctrl_ff.left_align ? {value12, 4'h0} : {4'h0, value12};
            RES_10BIT:
                formatted = conv_ctrl_ff.left_align ? {value12[11:2], 6'h00}
                                                    : {6'h00, value12[11:2]};
            RES_8BIT:
                formatted = conv_ctrl_ff.left_align ? {value12[11:4], 8'h00}
                                                    : {8'h00, value12[11:4]};
        endcase
    end

    wire         above      = formatted > window_lower_ff;
    wire         below      = formatted < window_upper_ff;
    wire         win_hit    = (window_mode_ff == WIN_ABOVE)   ? above
                            : (window_mode_ff == WIN_BELOW)   ? below
                            : (window_mode_ff == WIN_INSIDE)  ? (above & below)
                            : (window_mode_ff == WIN_OUTSIDE) ? ~(above & below)
                            : 1'b0;
    wire         storing    = (state_ff == ST_STORE) & ~flush_ff & enabled_ff;
    wire         win_clear  = wr_cycle & hit_stat & pwdata[ST_WINDOW_BIT];

    // Window flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff      <= 16'h0000;
            window_flag_ff <= 1'b0;
        end else begin
            result_ff      <= storing ? formatted : result_ff;
            window_flag_ff <= (storing & win_hit) | (window_flag_ff & ~win_clear);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sample <= 1'b0;
            core_start  <= 1'b0;
            core_abort  <= 1'b0;
            conv_tick   <= 1'b0;
            core_cfg    <= '0;
        end else begin
            core_sample <= (nxt_state == ST_SAMPLE);
            core_start  <= (state_ff == ST_SAMPLE) && (nxt_state == ST_CONVERT);
            core_abort  <= flush_ff;
            conv_tick   <= half_tick;
            core_cfg    <= {conv_ctrl_ff.differential_select, conv_ctrl_ff.resolution_select};
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sample_len;
        (state_ff == ST_SAMPLE) && samp_done && !flush_ff && enabled_ff
            |=> (state_ff == ST_CONVERT) && core_start;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample length wrong");

    property p_reserved_zero;
        setup_rd && !pwrite && hit_samp |=> prdata[31:6] == 26'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_prescale;
        enabled_ff && !flush_ff && !half_tick |=> presc_cnt_ff == $past(presc_cnt_ff) + 9'h001;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler period wrong");

    property p_enable_protect;
        wr_ok && hit_conv && enabled_ff |=> $stable(conv_ctrl_ff);
    endproperty
    a_enable_protect: assert property (p_enable_protect) else $error("locked setting changed");

    property p_res8;
        storing && conv_ctrl_ff.resolution_select == RES_8BIT && !conv_ctrl_ff.left_align
            |=> result_ff[15:8] == 8'h00;
    endproperty
    a_res8: assert property (p_res8) else $error("8-bit result too wide");

    property p_left12;
        storing && conv_ctrl_ff.resolution_select == RES_12BIT && conv_ctrl_ff.left_align
            |=> result_ff[3:0] == 4'h0 && result_ff[15:4] == $past(value12);
    endproperty
    a_left12: assert property (p_left12) else $error("left alignment wrong");

    property p_continuous;
        storing && restart |=> state_ff == ST_SAMPLE;
    endproperty
    a_continuous: assert property (p_continuous) else $error("no continuous restart");

    property p_start;
        go_sample && !set_start |=> state_ff == ST_SAMPLE && core_sample && !start_pend_ff;
    endproperty
    a_start: assert property (p_start) else $error("start did not begin");

    property p_zero_write;
        wr_trig && pwdata[1:0] == 2'b00 && !start_pend_ff && !flush_ff
            |=> !start_pend_ff && !flush_ff;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write acted");

    property p_flush;
        flush_ff |=> state_ff == ST_IDLE && presc_cnt_ff == 9'h000 && core_abort;
    endproperty
    a_flush: assert property (p_flush) else $error("flush did not abort");

    property p_flush_clear;
        flush_ff && !set_flush |=> !flush_ff;
    endproperty
    a_flush_clear: assert property (p_flush_clear) else $error("flush stuck");

    property p_resume;
        flush_ff && !state_ff[0] |=> start_pend_ff;
    endproperty
    a_resume: assert property (p_resume) else $error("pending lost on flush");

    property p_sync;
        wr_ok && hit_en |=> sync_busy ##[1:3] !sync_busy && enabled_ff == enable_req_ff;
    endproperty
    a_sync: assert property (p_sync) else $error("sync busy wrong");

    property p_window;
        storing && win_hit |=> window_flag_ff;
    endproperty
    a_window: assert property (p_window) else $error("window flag missed");

    c_flush_busy: cover property (flush_ff && !state_ff[0]);
    c_window_hit: cover property (storing && win_hit);
    c_correct:    cover property (state_ff == ST_CORRECT ##1 state_ff == ST_STORE);
    c_continuous: cover property (storing && restart);
endmodule
`default_nettype wire

/* testbench/adc_core_model.sv */
/*
 Behavioural analog core: answers each core_start with core_done and a fixed raw code.
 Assumes it shares pclk with the control block; abort cancels a pending answer.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_core_model #(
    parameter logic [11:0] RAW_CODE = 12'hABC,
    parameter int          DELAY    = 5
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Core handshake
    input  wire logic        core_start,
    input  wire logic        core_abort,
    output logic             core_done,
    output logic [11:0]      core_raw
);
    int cnt_ff;
    // Raw data only holds a real code with core_done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 0;
            core_done <= 1'b0;
            core_raw <= 12'h000;
        end else begin
            core_done <= (cnt_ff == 1);
            core_raw <= (cnt_ff == 1) ? RAW_CODE : ~core_raw;
            if (core_abort)
                cnt_ff <= 0;
            else if (core_start)
                cnt_ff <= DELAY;
            else if (cnt_ff != 0)
                cnt_ff <= cnt_ff - 1;
        end
    end
endmodule
`default_nettype wire

/* testbench/adc_conversion_control_tb.sv */
/*
 Self-checking bench for the converter control block over APB.
 Assumes the core model returns raw code 0xABC five cycles after core_start.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, write_lock = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, core_sample, core_start, core_abort, conv_tick, core_done;
    logic [11:0] core_raw;
    core_cfg_t core_cfg;
    int bad_count = 0, check_count = 0;

    adc_conversion_control DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .write_lock(write_lock),
        .core_sample(core_sample), .core_start(core_start), .core_abort(core_abort),
        .conv_tick(conv_tick), .core_cfg(core_cfg), .core_done(core_done), .core_raw(core_raw));
    adc_core_model core (.pclk(pclk), .presetn(presetn), .core_start(core_start),
        .core_abort(core_abort), .core_done(core_done), .core_raw(core_raw));

    initial forever #25 pclk = ~pclk;

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task fail(input string nm);
        bad_count++;
        $display("CHECK FAILED %s expected event seen timeout", nm);
        wrap_up();
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20)
            fail("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Sync delay is fixed at three cycles
    task en(input logic e);
        apb(1'b1, 8'h00, {30'h0, e, 1'b0});
        repeat (6) @(posedge pclk);
    endtask
    task wait_done;
        int n;
        n = 0;
        while (core_done !== 1'b1 && n < 800) begin
            @(posedge pclk);
            n++;
        end
        if (n == 800)
            fail("core_done");
        repeat (12) @(posedge pclk);
    endtask
    task t_regs;
        logic [7:0] a[4] = '{8'h0C, 8'h10, 8'h20, 8'h30};
        foreach (a[i]) begin
            apb(1'b0, a[i], 0);
            chk("reset_value", 0, rd);
        end
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        apb(1'b0, 8'h0C, 0);
        chk("sampling_time", 32'h0000_003F, rd);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        apb(1'b0, 8'h10, 0);
        chk("conversion_control", 32'h0000_073F, rd);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        apb(1'b0, 8'h20, 0);
        chk("window_mode", 32'h0000_0007, rd);
        write_lock <= 1'b1;
        apb(1'b1, 8'h0C, 32'h0000_0005);
        chk("lock_error", 1, err);
        write_lock <= 1'b0;
        apb(1'b0, 8'h0C, 0);
        chk("locked_value", 32'h0000_003F, rd);
        apb(1'b0, 8'hFC, 0);
        chk("unmapped_error", 1, err);
        apb(1'b1, 8'h10, 0);
        apb(1'b1, 8'h20, 0);
        $display("test regs finished");
    endtask
    task t_enable;
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b0, 8'h18, 0);
        chk("sync_busy_set", 1, rd[0]);
        apb(1'b0, 8'h00, 0);
        chk("enable_readback", 2, rd);
        repeat (6) @(posedge pclk);
        apb(1'b0, 8'h18, 0);
        chk("sync_busy_clear", 0, rd[0]);
        apb(1'b1, 8'h10, 32'h0000_0004);
        apb(1'b0, 8'h10, 0);
        chk("locked_while_enabled", 0, rd);
        $display("test enable finished");
    endtask
    task t_ticks;
        int n;
        for (int p = 0; p < 8; p++) begin
            en(1'b0);
            apb(1'b1, 8'h10, p << 8);
            en(1'b1);
            n = 0;
            while (conv_tick !== 1'b1 && n < 600) begin
                @(posedge pclk);
                n++;
            end
            if (n == 600) fail("tick");
            @(posedge pclk);
            n = 1;
            while (conv_tick !== 1'b1 && n < 600) begin
                @(posedge pclk);
                n++;
            end
            chk("tick_period", 2 << p, n);
            if (n == 600) fail("tick");
        end
        $display("test ticks finished");
    endtask
    task t_sample;
        int n;
        en(1'b0);
        apb(1'b1, 8'h0C, 3);
        apb(1'b1, 8'h10, 0);
        en(1'b1);
        apb(1'b1, 8'h30, 2);
        n = 0;
        while (core_sample !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) fail("sample");
        n = 0;
        while (core_sample === 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("sample_cycles", 1, n >= 7 && n <= 8);
        if (n == 100) fail("sample");
        apb(1'b0, 8'h30, 0);
        chk("start_cleared", 0, rd);
        wait_done();
        $display("test sample finished");
    endtask
    task t_res;
        logic [15:0] c[6] = '{16'h0000, 16'h0002, 16'h0020, 16'h0030, 16'h0010, 16'h0009};
        logic [15:0] x[6] = '{16'h0ABC, 16'hABC0, 16'h02AF, 16'h00AB, 16'h0ABC, 16'h055E};
        apb(1'b1, 8'h90, 32'h0000_0400);
        foreach (c[i]) begin
            en(1'b0);
            apb(1'b1, 8'h10, c[i]);
            en(1'b1);
            apb(1'b1, 8'h30, 2);
            wait_done();
            apb(1'b0, 8'h68, 0);
            chk("result", x[i], rd);
            chk("core_cfg", {c[i][0], c[i][5:4]}, core_cfg);
        end
        en(1'b0);
        apb(1'b1, 8'h10, 0);
        en(1'b1);
        $display("test resolution finished");
    endtask
    task t_zero;
        int n;
        apb(1'b1, 8'h30, 0);
        n = 0;
        repeat (60) begin
            @(posedge pclk);
            n += core_sample;
        end
        chk("zero_trigger", 0, n);
        $display("test zero finished");
    endtask
    task t_window;
        logic [7:0] hit = 8'b0000_1110;
        apb(1'b1, 8'h70, 32'h0000_0100);
        apb(1'b1, 8'h80, 32'h0000_0F00);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, 8'h18, 2);
            apb(1'b1, 8'h20, m);
            apb(1'b1, 8'h30, 2);
            wait_done();
            apb(1'b0, 8'h18, 0);
            chk("window_hit", hit[m], rd[1]);
        end
        $display("test window finished");
    endtask
    task t_flush;
        int n;
        en(1'b0);
        apb(1'b1, 8'h0C, 32'h0000_0014);
        apb(1'b1, 8'h10, 32'h0000_0200);
        en(1'b1);
        apb(1'b1, 8'h30, 2);
        n = 0;
        while (core_sample !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) fail("sample");
        apb(1'b1, 8'h30, 1);
        n = 0;
        while (core_abort !== 1'b1 && n < 6) begin
            @(posedge pclk);
            n++;
        end
        chk("abort_pulse", 1, n < 6);
        if (n == 6) fail("abort");
        apb(1'b0, 8'h30, 0);
        chk("flush_cleared", 0, rd);
        n = 0;
        while (core_sample !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk("resumed", 1, n < 200);
        if (n == 200) fail("resume");
        wait_done();
        $display("test flush finished");
    endtask
    task t_free;
        int n;
        en(1'b0);
        apb(1'b1, 8'h0C, 0);
        apb(1'b1, 8'h10, 32'h0000_0004);
        en(1'b1);
        apb(1'b1, 8'h30, 2);
        n = 0;
        repeat (300) begin
            @(posedge pclk);
            n += core_start;
        end
        chk("restarts", 1, n >= 3);
        en(1'b0);
        $display("test continuous finished");
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_enable();
        t_ticks();
        t_sample();
        t_res();
        t_zero();
        t_window();
        t_flush();
        t_free();
        wrap_up();
    end
endmodule
`default_nettype wire
